// ===== logic/twbm_master.sv
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "twbm_consts.svh"

module twbm_master (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Two-wire bus, open drain
    input wire twbm_pkg::twbm_line_t lineIn,
    output twbm_pkg::twbm_line_t lineOut,
    output twbm_pkg::twbm_line_t lineOen
);

    twbm_pkg::twbm_state_t state_q;
    twbm_pkg::twbm_line_t lineS;
    logic resp_q;
    logic [7:0] bitTime_q;
    logic [5:0] cmd_q;
    logic [7:0] status_q;
    logic [7:0] addr_q;
    logic [7:0] rxByte_q;
    logic [7:0] tx_q;
    logic [15:0] cnt_q;
    logic [1:0] quarter_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic isRx_q;
    logic isAddr_q;
    logic ackReq_q;
    logic err_q;
    logic ackSeen_q;
    logic rep_q;
    logic started_q;
    logic sclOen_q;
    logic sdaOen_q;
    logic [15:0] quarterLen;
    logic stall;
    logic tick;
    logic lastTick;
    logic startDone;
    logic stopDone;
    logic byteDone;
    logic badCmd;
    logic goCmd;
    logic busWr;

    twbm_sync #(
        .WIDTH(2)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .asyncIn(lineIn),
        .syncOut(lineS)
    );

    // Bus slave: one wait cycle on every access
    assign waitrequest = (read | write) & ~resp_q;
    assign busWr = write & resp_q & byteenable[0];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resp_q <= 1'b0;
        end else begin
            resp_q <= (read | write) & ~resp_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && !resp_q) begin
            case (address)
                `TWBM_OFS_BIT_TIME: readdata <= {24'h00_0000, bitTime_q};
                `TWBM_OFS_CMD: readdata <= {26'h000_0000, cmd_q};
                `TWBM_OFS_STATUS: readdata <= {24'h00_0000, status_q};
                `TWBM_OFS_ADDR: readdata <= {24'h00_0000, addr_q};
                `TWBM_OFS_RX: readdata <= {24'h00_0000, rxByte_q};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bitTime_q <= `TWBM_RST_BIT_TIME;
            addr_q <= `TWBM_RST_ADDR;
            tx_q <= `TWBM_RST_TX;
        end else if (busWr) begin
            if (address == `TWBM_OFS_BIT_TIME) begin
                bitTime_q <= writedata[7:0];
            end
            if (address == `TWBM_OFS_ADDR) begin
                addr_q <= writedata[7:0];
            end
            if (address == `TWBM_OFS_TX) begin
                tx_q <= writedata[7:0];
            end
        end
    end

    // Command decode
    assign goCmd = (state_q == twbm_pkg::TWBM_IDLE) && (cmd_q != 6'h00) && (bitTime_q != 8'h00);
    assign badCmd = goCmd && (!$onehot(cmd_q) || ((|cmd_q[3:0]) && !started_q));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= 6'h00;
        end else if (bitTime_q == 8'h00 || badCmd || startDone || stopDone || byteDone) begin
            cmd_q <= 6'h00;
        end else if (busWr && address == `TWBM_OFS_CMD && cmd_q == 6'h00) begin
            cmd_q <= writedata[5:0];
        end
    end

    // Quarter-bit timer; stretched in quarter 1 while the released clock line still reads low
    assign quarterLen = (((16'(bitTime_q) * 16'(`TWBM_CYC_PER_US)) >> 2) == 16'h0000) ? 16'h0001 :
                        ((16'(bitTime_q) * 16'(`TWBM_CYC_PER_US)) >> 2);
    assign stall = (quarter_q == 2'd1) && !lineS.scl;
    assign tick = (state_q != twbm_pkg::TWBM_IDLE) && !stall && (cnt_q >= quarterLen - 16'h0001);
    assign lastTick = tick && (quarter_q == 2'd3);
    assign startDone = lastTick && (state_q == twbm_pkg::TWBM_START);
    assign stopDone = lastTick && (state_q == twbm_pkg::TWBM_STOP);
    assign byteDone = lastTick && (state_q == twbm_pkg::TWBM_BYTE) && (bit_q == `TWBM_ACK_BIT);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            quarter_q <= 2'd0;
        end else if (state_q == twbm_pkg::TWBM_IDLE) begin
            cnt_q <= 16'h0000;
            quarter_q <= 2'd0;
        end else if (tick) begin
            cnt_q <= 16'h0000;
            quarter_q <= quarter_q + 2'd1;
        end else if (!stall) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Bus engine
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= twbm_pkg::TWBM_IDLE;
            sclOen_q <= 1'b1;
            sdaOen_q <= 1'b1;
            started_q <= 1'b0;
            rep_q <= 1'b0;
            bit_q <= 4'd0;
            shift_q <= 8'h00;
            isRx_q <= 1'b0;
            isAddr_q <= 1'b0;
            ackReq_q <= 1'b0;
            err_q <= 1'b0;
            ackSeen_q <= 1'b0;
        end else if (bitTime_q == 8'h00) begin
            state_q <= twbm_pkg::TWBM_IDLE;
            sclOen_q <= 1'b1;
            sdaOen_q <= 1'b1;
            started_q <= 1'b0;
        end else begin
            unique case (state_q)
                twbm_pkg::TWBM_IDLE: begin
                    if (goCmd && !badCmd) begin
                        err_q <= 1'b0;
                        bit_q <= 4'd0;
                        if (cmd_q[`TWBM_CMD_START]) begin
                            state_q <= twbm_pkg::TWBM_START;
                            rep_q <= started_q;
                            sdaOen_q <= 1'b1;
                        end else if (cmd_q[`TWBM_CMD_STOP]) begin
                            state_q <= twbm_pkg::TWBM_STOP;
                            if (!sclOen_q) begin
                                sdaOen_q <= 1'b0;
                            end
                        end else begin
                            state_q <= twbm_pkg::TWBM_BYTE;
                            isAddr_q <= cmd_q[`TWBM_CMD_ADDR];
                            isRx_q <= cmd_q[`TWBM_CMD_RX_ACK] | cmd_q[`TWBM_CMD_RX_NACK];
                            ackReq_q <= cmd_q[`TWBM_CMD_RX_ACK];
                            if (cmd_q[`TWBM_CMD_ADDR]) begin
                                shift_q <= addr_q;
                                sdaOen_q <= addr_q[7];
                            end else if (cmd_q[`TWBM_CMD_TX]) begin
                                shift_q <= tx_q;
                                sdaOen_q <= tx_q[7];
                            end else begin
                                shift_q <= 8'h00;
                                sdaOen_q <= 1'b1;
                            end
                        end
                    end
                end
                twbm_pkg::TWBM_START: begin
                    if (tick) begin
                        unique case (quarter_q)
                            2'd0: sclOen_q <= 1'b1;
                            2'd1: sdaOen_q <= 1'b0;
                            2'd2: sclOen_q <= 1'b0;
                            2'd3: begin
                                state_q <= twbm_pkg::TWBM_IDLE;
                                started_q <= 1'b1;
                            end
                        endcase
                    end
                end
                twbm_pkg::TWBM_STOP: begin
                    if (tick) begin
                        unique case (quarter_q)
                            2'd0: sclOen_q <= 1'b1;
                            2'd1: sdaOen_q <= 1'b1;
                            2'd2: sdaOen_q <= 1'b1;
                            2'd3: begin
                                state_q <= twbm_pkg::TWBM_IDLE;
                                started_q <= 1'b0;
                            end
                        endcase
                    end
                end
                twbm_pkg::TWBM_BYTE: begin
                    if (tick) begin
                        unique case (quarter_q)
                            2'd0: sclOen_q <= 1'b1;
                            2'd1: begin
                                if (bit_q == `TWBM_ACK_BIT) begin
                                    ackSeen_q <= !lineS.sda;
                                end else if (isRx_q) begin
                                    shift_q <= {shift_q[6:0], lineS.sda};
                                end else if (sdaOen_q && !lineS.sda) begin
                                    err_q <= 1'b1;
                                end
                            end
                            2'd2: sclOen_q <= 1'b0;
                            2'd3: begin
                                if (bit_q == `TWBM_ACK_BIT) begin
                                    state_q <= twbm_pkg::TWBM_IDLE;
                                    sdaOen_q <= 1'b1;
                                end else begin
                                    bit_q <= bit_q + 4'd1;
                                    if (bit_q == 4'd7) begin
                                        sdaOen_q <= isRx_q ? !ackReq_q : 1'b1;
                                    end else begin
                                        sdaOen_q <= isRx_q ? 1'b1 : shift_q[6];
                                    end
                                    if (!isRx_q) begin
                                        shift_q <= {shift_q[6:0], 1'b0};
                                    end
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // Lines are only ever pulled low or released
    assign lineOut = '0;
    assign lineOen = '{scl: sclOen_q, sda: sdaOen_q};

    // Receive register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxByte_q <= 8'h00;
        end else if (byteDone && isRx_q) begin
            rxByte_q <= shift_q;
        end
    end

    // Status codes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= `TWBM_SC_IDLE;
        end else if (badCmd) begin
            status_q <= `TWBM_SC_GEN_ERR;
        end else if (startDone) begin
            status_q <= rep_q ? `TWBM_SC_RSTART : `TWBM_SC_START;
        end else if (stopDone) begin
            status_q <= `TWBM_SC_IDLE;
        end else if (byteDone) begin
            if (isRx_q) begin
                status_q <= ackReq_q ? `TWBM_SC_RD_ACK : `TWBM_SC_RD_NACK;
            end else if (isAddr_q) begin
                if (err_q) begin
                    status_q <= `TWBM_SC_ADR_ERR;
                end else if (shift_q[0] == 1'b0 && addr_q[0]) begin
                    status_q <= ackSeen_q ? `TWBM_SC_RADR_ACK : `TWBM_SC_RADR_NACK;
                end else begin
                    status_q <= ackSeen_q ? `TWBM_SC_WADR_ACK : `TWBM_SC_WADR_NACK;
                end
            end else begin
                status_q <= err_q ? `TWBM_SC_WD_ERR : (ackSeen_q ? `TWBM_SC_WD_ACK : `TWBM_SC_WD_NACK);
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_disable_release: assert property ((bitTime_q == 8'h00) [*2] |-> lineOen == 2'b11)
        else $error("bus not released with zero bit time");
    a_start_code: assert property (startDone && !rep_q |=> status_q == 8'h01 && started_q)
        else $error("start status wrong");
    a_repeat_code: assert property (startDone && rep_q |=> status_q == 8'h02)
        else $error("repeated start status wrong");
    a_stop_idle: assert property (stopDone |=> status_q == 8'h00 && !started_q && lineOen == 2'b11)
        else $error("stop did not return to idle");
    a_addr_code: assert property (byteDone && isAddr_q |=>
        status_q inside {8'h34, 8'h2C, 8'h54, 8'h4C, 8'hE4})
        else $error("address status wrong");
    a_addr_dir: assert property (byteDone && isAddr_q && !err_q && ackSeen_q |=>
        status_q == (addr_q[0] ? 8'h2C : 8'h34))
        else $error("address direction not reported");
    a_tx_code: assert property (byteDone && !isAddr_q && !isRx_q |=> status_q inside {8'h30, 8'h50, 8'hF0})
        else $error("data sent status wrong");
    a_rx_code: assert property (byteDone && isRx_q |=> status_q == (ackReq_q ? 8'h48 : 8'h28))
        else $error("data received status wrong");
    a_rx_hold: assert property (!(byteDone && isRx_q) |=> $stable(rxByte_q))
        else $error("receive byte changed");
    a_cmd_clear: assert property (startDone || stopDone || byteDone || badCmd |=> cmd_q == 6'h00)
        else $error("command not cleared");
    a_data_change: assert property (state_q == twbm_pkg::TWBM_BYTE && $changed(sdaOen_q) |-> !sclOen_q)
        else $error("data changed while clock high");
    a_ack_drive: assert property (state_q == twbm_pkg::TWBM_BYTE && bit_q == 4'd8 && isRx_q &&
        quarter_q == 2'd1 |-> sdaOen_q == !ackReq_q)
        else $error("acknowledge bit wrong");

    c_start: cover property (startDone);
    c_addr_ack: cover property (byteDone && isAddr_q && ackSeen_q);
    c_rx_byte: cover property (byteDone && isRx_q);
    c_stop: cover property (stopDone);

endmodule

`default_nettype wire

// ===== common/twbm_consts.svh
`ifndef TWBM_CONSTS_SVH
`define TWBM_CONSTS_SVH

// Register byte offsets
`define TWBM_OFS_BIT_TIME 5'h00
`define TWBM_OFS_CMD 5'h04
`define TWBM_OFS_STATUS 5'h08
`define TWBM_OFS_ADDR 5'h0C
`define TWBM_OFS_RX 5'h10
`define TWBM_OFS_TX 5'h14

// Command bit positions
`define TWBM_CMD_START 5
`define TWBM_CMD_STOP 4
`define TWBM_CMD_ADDR 3
`define TWBM_CMD_TX 2
`define TWBM_CMD_RX_ACK 1
`define TWBM_CMD_RX_NACK 0

// Status bit positions
`define TWBM_ST_ERR 7
`define TWBM_ST_NACK 6
`define TWBM_ST_ACK 5
`define TWBM_ST_WR 4
`define TWBM_ST_RD 3
`define TWBM_ST_ADR 2
`define TWBM_ST_RSTART 1
`define TWBM_ST_START 0

// Status codes
`define TWBM_SC_IDLE 8'h00
`define TWBM_SC_START 8'h01
`define TWBM_SC_RSTART 8'h02
`define TWBM_SC_WADR_ACK 8'h34
`define TWBM_SC_RADR_ACK 8'h2C
`define TWBM_SC_WADR_NACK 8'h54
`define TWBM_SC_RADR_NACK 8'h4C
`define TWBM_SC_ADR_ERR 8'hE4
`define TWBM_SC_RD_ACK 8'h48
`define TWBM_SC_RD_NACK 8'h28
`define TWBM_SC_WD_ACK 8'h30
`define TWBM_SC_WD_NACK 8'h50
`define TWBM_SC_WD_ERR 8'hF0
`define TWBM_SC_GEN_ERR 8'hFF

// Reset values
`define TWBM_RST_BIT_TIME 8'h00
`define TWBM_RST_ADDR 8'h00
`define TWBM_RST_TX 8'h00

// Timing
`define TWBM_US_NS 1000
`define TWBM_CLK_NS 8
`define TWBM_CYC_PER_US (`TWBM_US_NS / `TWBM_CLK_NS)
`define TWBM_QUARTERS 4
`define TWBM_ACK_BIT 4'd8

`endif

// ===== common/twbm_pkg.sv
package twbm_pkg;

    typedef enum logic [1:0] {
        TWBM_IDLE = 2'b00,
        TWBM_START = 2'b01,
        TWBM_BYTE = 2'b11,
        TWBM_STOP = 2'b10
    } twbm_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } twbm_line_t;

endpackage

// ===== logic/twbm_sync.sv
`timescale 1ns/1ps
`default_nettype none

module twbm_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '1;
            syncOut <= '1;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ===== bench/twbm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module twbm_slave_model #(
    parameter logic [6:0] OWN_ADDR = 7'h2A
) (
    // Bus wires
    input wire logic scl,
    input wire logic sda,
    // Behaviour controls
    input wire logic [7:0] rdByte,
    input wire logic nackData,
    input wire logic jam,
    input wire logic stretch,
    // Open-drain pulls and capture
    output logic sdaLow,
    output logic sclLow,
    output logic [7:0] lastWr
);
    logic [7:0] sh;
    logic active, isAdr, rd, mAck;
    int bitCnt;

    initial begin
        {sdaLow, sclLow, active, isAdr, rd, mAck} = '0;
        lastWr = 8'h00;
        sh = 8'h00;
        bitCnt = 0;
    end
    // Start or repeated start; the closing clock fall brings the count to 0
    always @(negedge sda) begin
        if (scl) begin
            active = 1'b1;
            isAdr = 1'b1;
            rd = 1'b0;
            bitCnt = -1;
        end
    end
    always @(posedge sda) begin
        if (scl) begin
            active = 1'b0;
            sdaLow = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (active && bitCnt >= 0 && bitCnt < 8) sh = {sh[6:0], sda};
        if (active && bitCnt == 8) mAck = !sda;
    end
    always @(negedge scl) begin
        if (active) begin
            bitCnt++;
            if (bitCnt == 8) begin
                sdaLow = !rd && (isAdr ? sh[7:1] == OWN_ADDR : !nackData);
            end else if (bitCnt == 9) begin
                bitCnt = 0;
                if (isAdr) begin
                    rd = sh[0] && sh[7:1] == OWN_ADDR;
                    mAck = 1'b1;
                end else if (!rd) begin
                    lastWr = sh;
                end
                isAdr = 1'b0;
                // Released after a master NACK so that stop can be seen
                sdaLow = rd && mAck && !rdByte[7];
            end else if (bitCnt > 0) begin
                sdaLow = rd ? !rdByte[7 - bitCnt] : jam;
            end
        end
    end
    // Slow device: holds the clock low past the master's own low phase
    always @(negedge scl) begin
        if (stretch && active) begin
            sclLow = 1'b1;
            #2000;
            sclLow = 1'b0;
        end
    end
endmodule

`default_nettype wire

// ===== bench/test_two_wire_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "twbm_consts.svh"

module test_two_wire_bus_master;
    logic clock, rst_n, read, write, waitrequest;
    logic [4:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    twbm_pkg::twbm_line_t lineOut, lineOen;
    wire twbm_pkg::twbm_line_t lineIn;
    logic sdaLow, sclLow, nackData, jam, stretch;
    logic [7:0] rdByte, lastWr, d, q;
    int fails, numChecks, seed, lastEdge, period, cyc;

    // Wired-AND with pull-ups
    assign lineIn = {(lineOen.scl | lineOut.scl) & ~sclLow, (lineOen.sda | lineOut.sda) & ~sdaLow};

    twbm_master u_dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .lineIn(lineIn), .lineOut(lineOut), .lineOen(lineOen));
    twbm_slave_model u_slave (.scl(lineIn.scl), .sda(lineIn.sda), .rdByte(rdByte), .nackData(nackData),
        .jam(jam), .stretch(stretch), .sdaLow(sdaLow), .sclLow(sclLow), .lastWr(lastWr));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
    end
    always @(posedge lineIn.scl) begin
        period = cyc - lastEdge;
        lastEdge = cyc;
    end

    task automatic stopTest();
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] dat, input logic [3:0] be,
                       output logic [7:0] rv);
        int n;
        n = 0;
        address <= a;
        writedata <= {24'h000000, dat};
        byteenable <= be;
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rv = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        // Idle edge so the next request never reuses this time step
        @(posedge clock);
        if (n >= 20) begin
            fails++;
            stopTest();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] dat);
        bus(1'b1, a, dat, 4'hF, q);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [7:0] exp, input string what);
        bus(1'b0, a, 8'h00, 4'hF, q);
        chk(q, exp, what);
    endtask

    // Issue a command, poll until it clears, then compare the status
    task automatic cmd(input logic [7:0] c, input logic [7:0] expSt);
        int n;
        n = 0;
        wr(`TWBM_OFS_CMD, c);
        do begin
            bus(1'b0, `TWBM_OFS_CMD, 8'h00, 4'hF, q);
            n++;
        end while (q !== 8'h00 && n < 3000);
        if (n >= 3000) begin
            fails++;
            stopTest();
        end
        rdc(`TWBM_OFS_STATUS, expSt, "status");
    endtask

    // Four quarters plus the two-cycle lag of the synchronised clock readback
    function automatic logic [15:0] bitCycles(input int bt);
        return 16'(4 * ((bt * 125) / 4) + 2);
    endfunction

    initial begin
        seed = 32'h5853;
        {read, write, nackData, jam, stretch} = '0;
        address = 5'h00;
        writedata = 32'h00000000;
        byteenable = 4'hF;
        rdByte = 8'h00;
        {fails, numChecks, cyc, lastEdge, period} = '0;
        rst_n = 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rdc(`TWBM_OFS_BIT_TIME, 8'h00, "bit time");
        rdc(`TWBM_OFS_STATUS, 8'h00, "status");
        rdc(`TWBM_OFS_ADDR, 8'h00, "address");
        rdc(`TWBM_OFS_RX, 8'h00, "rx byte");
        rdc(5'h18, 8'h00, "unmapped");
        chk(lineOen, 2'b11, "idle lines");
        wr(`TWBM_OFS_CMD, 8'h20);
        rdc(`TWBM_OFS_CMD, 8'h00, "cmd while disabled");
        rdc(`TWBM_OFS_STATUS, 8'h00, "status");
        chk(lineOen, 2'b11, "disabled lines");
        bus(1'b1, `TWBM_OFS_BIT_TIME, 8'h01, 4'h0, q);
        rdc(`TWBM_OFS_BIT_TIME, 8'h00, "masked write");
        wr(`TWBM_OFS_BIT_TIME, 8'h01);
        rdc(`TWBM_OFS_BIT_TIME, 8'h01, "bit time");
        cmd(8'h08, 8'hFF);
        cmd(8'h10, 8'h00);
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed)) | 8'h01;
            rdByte <= 8'($random(seed));
            stretch <= (i == 1);
            wr(`TWBM_OFS_BIT_TIME, 8'(i + 1));
            cmd(8'h20, 8'h01);
            wr(`TWBM_OFS_ADDR, 8'h54);
            cmd(8'h08, 8'h34);
            wr(`TWBM_OFS_TX, d);
            cmd(8'h04, 8'h30);
            chk(lastWr, d, "slave byte");
            if (i != 1) chk(16'(period), bitCycles(i + 1), "bit period");
            cmd(8'h20, 8'h02);
            wr(`TWBM_OFS_ADDR, 8'h55);
            cmd(8'h08, 8'h2C);
            cmd(8'h02, 8'h48);
            rdc(`TWBM_OFS_RX, rdByte, "rx ack");
            cmd(8'h01, 8'h28);
            cmd(8'h10, 8'h00);
            rdc(`TWBM_OFS_RX, rdByte, "rx held");
        end
        stretch <= 1'b0;
        wr(`TWBM_OFS_BIT_TIME, 8'h01);
        cmd(8'h20, 8'h01);
        wr(`TWBM_OFS_ADDR, 8'h56);
        cmd(8'h08, 8'h54);
        cmd(8'h20, 8'h02);
        wr(`TWBM_OFS_ADDR, 8'h57);
        cmd(8'h08, 8'h4C);
        cmd(8'h20, 8'h02);
        wr(`TWBM_OFS_ADDR, 8'h54);
        cmd(8'h08, 8'h34);
        nackData <= 1'b1;
        cmd(8'h04, 8'h50);
        nackData <= 1'b0;
        jam <= 1'b1;
        cmd(8'h04, 8'hF0);
        cmd(8'h10, 8'h00);
        cmd(8'h20, 8'h01);
        cmd(8'h08, 8'hE4);
        jam <= 1'b0;
        cmd(8'h10, 8'h00);
        cmd(8'h0C, 8'hFF);
        cmd(8'h10, 8'h00);
        chk(lineOut, 2'b00, "pull value");
        chk(lineOen, 2'b11, "released lines");
        stopTest();
    end
endmodule

`default_nettype wire
